// File: inc/lcdhif_pkg.sv
/*
 * lcdhif_pkg: shared constants and carrier types for the display driver host port.
 * assumes: no imports anywhere; every use is written with the package scope.
 */
package lcdhif_pkg;
    // serial and i2c byte framing
    localparam int BIT_CNT_W = 3;                       // serial bit counter width
    localparam logic [2:0] BIT_CNT_RST = 3'h0;          // counter value at reset / deselect
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;         // eighth edge forms the byte
    localparam logic [7:0] SHIFT_RST = 8'h00;           // shift register value at reset
    localparam int CTRL_CONT_POS = 7;                   // first control bit: more control bytes
    localparam int CTRL_RS_POS = 6;                     // second control bit: command or pixel
    localparam int ADDR_RW_POS = 0;                     // direction bit of address byte
    localparam logic [6:0] I2C_ADDR_HI_DEF = 7'h1C;     // upper five address bits, shifted left 2; arbitrary
    // system clock period, in nanoseconds
    localparam int CLK_SYS_NS = 10;
    localparam int FR_DIV_CYC = 4;                      // frame reversal toggle prescale (plain default)

    // host link selected by the straps
    typedef enum logic [3:0] {
        LCDHIF_PAR80 = 4'h1,
        LCDHIF_PAR68 = 4'h2,
        LCDHIF_SER   = 4'h4,
        LCDHIF_I2C   = 4'h8
    } lcdhif_mode_t;

    // i2c receive phases, one-hot
    typedef enum logic [3:0] {
        LCDHIF_I_IDLE = 4'h1,
        LCDHIF_I_ADDR = 4'h2,
        LCDHIF_I_CTRL = 4'h4,
        LCDHIF_I_DATA = 4'h8
    } lcdhif_i2c_st_t;

    // straps, captured once after reset release
    typedef struct packed {
        logic par_sel;            // high: parallel
        logic bus_family_select;  // family / serial kind
        logic osc_source_select;  // high: internal oscillator
        logic master_sel;         // high: timing master
    } lcdhif_strap_t;

    // one received transfer handed to the core
    typedef struct packed {
        logic [7:0] data;
        logic is_pixel;           // high: display data, low: command
    } lcdhif_xfer_t;
endpackage : lcdhif_pkg

// File: src/lcdhif_top.sv
/*
 * lcdhif_top: host interface and strapping of a dot-matrix display driver.
 * parallel 80/68 bus, clocked serial and write-only i2c are decoded on a link clock
 * (the host strobe / serial clock, ticking only while the host transfers); results
 * cross to CLK_SYS by toggle handshake. assumes straps are static and that the
 * board resolves each tri-state pin from output, output-enable pairs.
 */
// Function
// - serial: bit7 data, bit6 clock
// - serial/i2c: bus bits 0..5 undriven
// - deselected: whole data bus undriven
// - data/command high means display data
// - reset low initialises, held while low
// - parallel/serial need select-low low, select-high high
// - i2c: chip selects give address bits 1..0
// - 80-style: drive bus only while read low
// - 68-style: read pin is enable clock
// - 80-style: capture on write rising edge
// - 68-style: write pin high read, low write
// - family select picks 68/80 or serial/i2c
// - parallel select picks parallel or serial-class
// - serial-class links give no readback
// - i2c ack on separate open-drain output
// - osc select high runs oscillator
// - oscillator off: display clock from pin
// - clock pin output only master and osc
// - master high drives timing, else follows
// - frame reversal pin out in master
// - blanking pin out in master
// - serial msb first, byte on 8th edge
// - deselect clears shift and counter
// - i2c control byte: continue and command/pixel
`timescale 1ns/10ps
module lcdhif_top #(
    parameter logic [6:0] I2C_ADDR_HI = lcdhif_pkg::I2C_ADDR_HI_DEF  // arbitrary upper address bits
) (
    input wire logic CLK_SYS,              // system clock, 100 MHz
    input wire logic RST_B,                // async reset, active low (reset_input_low)
    input wire logic LINK_CLK,             // host strobe / serial clock domain
    input wire logic PAR_SEL,              // strap: parallel / serial-class
    input wire logic BUS_FAMILY_SELECT,    // strap: 68/80 or serial/i2c
    input wire logic OSC_SOURCE_SELECT,    // strap: internal oscillator
    input wire logic MASTER_SEL,           // strap: timing master
    input wire logic CHIP_SELECT_LOW_B,    // first chip select (slave_addr_bit_zero in i2c)
    input wire logic CHIP_SELECT_HIGH,     // second chip select (slave_addr_bit_one in i2c)
    input wire logic DATA_COMMAND_SELECT,  // high: display data
    input wire logic RD_STROBE,            // 80: read low; 68: enable
    input wire logic WR_STROBE,            // 80: write low; 68: direction
    input wire logic [7:0] HOST_DATA_BUS_I,// data bus level
    input wire logic I2C_START,            // start seen on the line, link domain
    input wire logic [7:0] READ_DATA,      // core data offered for readback
    input wire logic OSC_CLK,              // internal oscillator tick
    input wire logic DISPLAY_CLOCK_PIN_I,  // display clock pin level
    input wire logic FRAME_REVERSAL_SIGNAL_I,
    input wire logic DISPLAY_BLANK_SIGNAL_I,
    input wire logic BLANK_REQ,            // core blanking request in master
    output logic [7:0] HOST_DATA_BUS_O,    // read data
    output logic [7:0] HOST_DATA_BUS_OE,   // per-bit drive enable
    output logic ACK_OPEN_DRAIN_OUT_O,     // always low when enabled
    output logic ACK_OPEN_DRAIN_OUT_OE,    // pull ack low
    output logic XFER_VALID,               // one-cycle pulse, CLK_SYS
    output logic [7:0] XFER_DATA,
    output logic XFER_IS_PIXEL,
    output logic OSC_ENABLE,               // run internal oscillator
    output logic DISP_CLK,                 // display clock in use, sys domain
    output logic DISPLAY_CLOCK_PIN_O,
    output logic DISPLAY_CLOCK_PIN_OE,
    output logic FRAME_REVERSAL_SIGNAL_O,
    output logic FRAME_REVERSAL_SIGNAL_OE,
    output logic DISPLAY_BLANK_SIGNAL_O,
    output logic DISPLAY_BLANK_SIGNAL_OE,
    output logic FRAME_REVERSAL,           // frame reversal seen by the core
    output logic DISPLAY_BLANK             // blanking seen by the core
);
    // link-domain state
    typedef struct packed {
        logic [7:0] shift;                    // serial / i2c shift register
        logic [2:0] bcnt;                     // bit counter
        lcdhif_pkg::lcdhif_i2c_st_t ist;      // i2c phase
        logic cont;                           // more control bytes follow
        logic rs;                             // command or pixel for data bytes
        logic ack;                            // ack pending on the ninth bit
        logic ninth;                          // on the acknowledge bit
        lcdhif_pkg::lcdhif_xfer_t xfer;       // last byte taken
        logic tgl;                            // toggles once per byte
    } lcdhif_lnk_t;

    // system-domain state
    typedef struct packed {
        lcdhif_pkg::lcdhif_strap_t strap;
        logic strap_done;                     // straps caught
        logic [1:0] tgl_s;                    // toggle synchroniser
        logic tgl_seen;
        logic [1:0] rd_s, wr_s, cs1_s, cs2_s; // two-stage pin synchronisers
        logic [1:0] dclk_s, fr_s, dof_s, osc_s;
        logic [7:0] bus_o;
        logic [7:0] bus_oe;
        logic valid;
        lcdhif_pkg::lcdhif_xfer_t out;
        logic osc_en;
        logic dclk;
        logic dclk_o, dclk_oe;
        logic fr_o, fr_oe, dof_o, dof_oe;
        logic fr, display_blank_signal;
        logic [2:0] fr_div;
        logic ack_oe;
        logic [1:0] ack_s;
    } lcdhif_sys_t;

    lcdhif_lnk_t l_q, l_d;
    lcdhif_sys_t s_q, s_d;

    // link domain reads straps only through this quasi-static copy
    lcdhif_pkg::lcdhif_mode_t mode;
    logic selected;

    // decode strap pair into a link, used by both domains
    function automatic lcdhif_pkg::lcdhif_mode_t mode_of(input lcdhif_pkg::lcdhif_strap_t s);
        if (s.par_sel) begin
            mode_of = s.bus_family_select ? lcdhif_pkg::LCDHIF_PAR68 : lcdhif_pkg::LCDHIF_PAR80;
        end else begin
            mode_of = s.bus_family_select ? lcdhif_pkg::LCDHIF_SER : lcdhif_pkg::LCDHIF_I2C;
        end
    endfunction : mode_of

    // straps are static after capture, so the link domain may read them unsynchronised
    assign mode = mode_of(s_q.strap);
    // chip selects are only meaningful in parallel and serial links
    assign selected = !CHIP_SELECT_LOW_B && CHIP_SELECT_HIGH;

    // link logic: byte assembly on the host's own clock
    always_comb begin
        l_d = l_q;
        unique case (mode)
            lcdhif_pkg::LCDHIF_PAR80: begin
                // link clock is the write strobe rising edge
                if (selected) begin
                    l_d.xfer.data = HOST_DATA_BUS_I;
                    l_d.xfer.is_pixel = DATA_COMMAND_SELECT;
                    l_d.tgl = !l_q.tgl;
                end
            end
            lcdhif_pkg::LCDHIF_PAR68: begin
                // link clock is the enable falling edge; direction low means write
                if (selected && !WR_STROBE) begin
                    l_d.xfer.data = HOST_DATA_BUS_I;
                    l_d.xfer.is_pixel = DATA_COMMAND_SELECT;
                    l_d.tgl = !l_q.tgl;
                end
            end
            lcdhif_pkg::LCDHIF_SER: begin
                if (!selected) begin
                    l_d.shift = lcdhif_pkg::SHIFT_RST;
                    l_d.bcnt = lcdhif_pkg::BIT_CNT_RST;
                end else begin
                    // bit 7 carries data, msb first
                    l_d.shift = {l_q.shift[6:0], HOST_DATA_BUS_I[7]};
                    l_d.bcnt = l_q.bcnt + 3'h1;
                    if (l_q.bcnt == lcdhif_pkg::BIT_CNT_LAST) begin
                        l_d.xfer.data = {l_q.shift[6:0], HOST_DATA_BUS_I[7]};
                        l_d.xfer.is_pixel = DATA_COMMAND_SELECT;
                        l_d.tgl = !l_q.tgl;
                    end
                end
            end
            default: begin
                // i2c write-only receiver on the serial clock
                l_d.ack = 1'b0;
                if (I2C_START) begin
                    l_d.ist = lcdhif_pkg::LCDHIF_I_ADDR;
                    // the edge after a start already carries the first address bit
                    l_d.shift = {l_q.shift[6:0], HOST_DATA_BUS_I[7]};
                    l_d.bcnt = 3'h1;
                    l_d.ninth = 1'b0;
                    l_d.cont = 1'b1;
                end else if (l_q.ninth) begin
                    l_d.ninth = 1'b0; // ack bit consumed
                end else if (l_q.ist != lcdhif_pkg::LCDHIF_I_IDLE) begin
                    l_d.shift = {l_q.shift[6:0], HOST_DATA_BUS_I[7]};
                    l_d.bcnt = l_q.bcnt + 3'h1;
                    if (l_q.bcnt == lcdhif_pkg::BIT_CNT_LAST) begin
                        l_d.ninth = 1'b1;
                        unique case (l_q.ist)
                            lcdhif_pkg::LCDHIF_I_ADDR: begin
                                // lowest two address bits come from the chip-select pins
                                if ({l_d.shift[7:1], 1'b0} == {I2C_ADDR_HI[6:2], CHIP_SELECT_HIGH,
                                        CHIP_SELECT_LOW_B, 1'b0} && !l_d.shift[lcdhif_pkg::ADDR_RW_POS]) begin
                                    l_d.ist = lcdhif_pkg::LCDHIF_I_CTRL;
                                    l_d.ack = 1'b1;
                                end else begin
                                    l_d.ist = lcdhif_pkg::LCDHIF_I_IDLE;
                                end
                            end
                            lcdhif_pkg::LCDHIF_I_CTRL: begin
                                l_d.cont = l_d.shift[lcdhif_pkg::CTRL_CONT_POS];
                                l_d.rs = l_d.shift[lcdhif_pkg::CTRL_RS_POS];
                                l_d.ist = lcdhif_pkg::LCDHIF_I_DATA;
                                l_d.ack = 1'b1;
                            end
                            lcdhif_pkg::LCDHIF_I_DATA: begin
                                l_d.xfer.data = l_d.shift;
                                l_d.xfer.is_pixel = l_q.rs;
                                l_d.tgl = !l_q.tgl;
                                l_d.ack = 1'b1;
                                // with continuation set, a control byte comes next
                                if (l_q.cont) begin
                                    l_d.ist = lcdhif_pkg::LCDHIF_I_CTRL;
                                end
                            end
                            default: begin
                                l_d.ist = lcdhif_pkg::LCDHIF_I_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // link registers; reset low holds everything at its initial value
    always_ff @(posedge LINK_CLK or negedge RST_B) begin
        if (!RST_B) begin
            l_q <= '0;
            l_q.ist <= lcdhif_pkg::LCDHIF_I_IDLE;
        end else begin
            l_q <= l_d;
        end
    end

    // system logic: straps, pin directions, readback, crossing
    always_comb begin
        lcdhif_pkg::lcdhif_mode_t m;
        m = mode_of(s_q.strap);
        s_d = s_q;
        // catch straps once on the first edge after release
        if (!s_q.strap_done) begin
            s_d.strap = '{PAR_SEL, BUS_FAMILY_SELECT, OSC_SOURCE_SELECT, MASTER_SEL};
            s_d.strap_done = 1'b1;
        end
        // pin synchronisers: stage 0 feeds stage 1 only
        s_d.rd_s = {s_q.rd_s[0], RD_STROBE};
        s_d.wr_s = {s_q.wr_s[0], WR_STROBE};
        s_d.cs1_s = {s_q.cs1_s[0], CHIP_SELECT_LOW_B};
        s_d.cs2_s = {s_q.cs2_s[0], CHIP_SELECT_HIGH};
        s_d.dclk_s = {s_q.dclk_s[0], DISPLAY_CLOCK_PIN_I};
        s_d.fr_s = {s_q.fr_s[0], FRAME_REVERSAL_SIGNAL_I};
        s_d.dof_s = {s_q.dof_s[0], DISPLAY_BLANK_SIGNAL_I};
        s_d.osc_s = {s_q.osc_s[0], OSC_CLK};
        s_d.tgl_s = {s_q.tgl_s[0], l_q.tgl};
        s_d.ack_s = {s_q.ack_s[0], l_q.ack};
        // one pulse per byte crossing from the link
        s_d.valid = s_q.tgl_s[1] != s_q.tgl_seen;
        s_d.tgl_seen = s_q.tgl_s[1];
        if (s_d.valid) begin
            s_d.out = l_q.xfer; // stable: changes only once per byte, on the same link edge as the toggle
        end
        // data bus drive; readback exists only in the parallel links
        s_d.bus_o = READ_DATA;
        s_d.bus_oe = 8'h00;
        if (!s_q.cs1_s[1] && s_q.cs2_s[1]) begin
            if (m == lcdhif_pkg::LCDHIF_PAR80 && !s_q.rd_s[1]) begin
                s_d.bus_oe = 8'hFF;
            end else if (m == lcdhif_pkg::LCDHIF_PAR68 && s_q.rd_s[1] && s_q.wr_s[1]) begin
                s_d.bus_oe = 8'hFF;
            end
        end
        // acknowledge pulls the separate open-drain pin
        s_d.ack_oe = (m == lcdhif_pkg::LCDHIF_I2C) && s_q.ack_s[1];
        // oscillator and display clock
        s_d.osc_en = s_q.strap.osc_source_select;
        s_d.dclk = s_q.strap.osc_source_select ? s_q.osc_s[1] : s_q.dclk_s[1];
        s_d.dclk_oe = s_q.strap.master_sel && s_q.strap.osc_source_select;
        s_d.dclk_o = s_q.osc_s[1];
        // timing master generates blanking, and frame reversal only with the internal oscillator; slave follows the pins
        if (s_q.strap.master_sel) begin
            if (s_q.dclk_s[1] != s_d.dclk && s_d.dclk) begin
                s_d.fr_div = s_q.fr_div + 3'h1;
                if (s_q.fr_div == 3'(lcdhif_pkg::FR_DIV_CYC - 1)) begin
                    s_d.fr_div = 3'h0;
                    s_d.fr = !s_q.fr;
                end
            end
            s_d.display_blank_signal = BLANK_REQ;
        end else begin
            s_d.fr = s_q.fr_s[1];
            s_d.display_blank_signal = s_q.dof_s[1];
        end
        s_d.fr_oe = s_q.strap.master_sel;
        s_d.fr_o = s_q.fr;
        s_d.dof_oe = s_q.strap.master_sel;
        s_d.dof_o = s_q.display_blank_signal;
    end

    // system registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ports straight from flip-flops, except the constant-low ACK_OPEN_DRAIN_OUT_O
    assign HOST_DATA_BUS_O = s_q.bus_o;
    assign HOST_DATA_BUS_OE = s_q.bus_oe;
    assign ACK_OPEN_DRAIN_OUT_O = 1'b0;
    assign ACK_OPEN_DRAIN_OUT_OE = s_q.ack_oe;
    assign XFER_VALID = s_q.valid;
    assign XFER_DATA = s_q.out.data;
    assign XFER_IS_PIXEL = s_q.out.is_pixel;
    assign OSC_ENABLE = s_q.osc_en;
    assign DISP_CLK = s_q.dclk;
    assign DISPLAY_CLOCK_PIN_O = s_q.dclk_o;
    assign DISPLAY_CLOCK_PIN_OE = s_q.dclk_oe;
    assign FRAME_REVERSAL_SIGNAL_O = s_q.fr_o;
    assign FRAME_REVERSAL_SIGNAL_OE = s_q.fr_oe;
    assign DISPLAY_BLANK_SIGNAL_O = s_q.dof_o;
    assign DISPLAY_BLANK_SIGNAL_OE = s_q.dof_oe;
    assign FRAME_REVERSAL = s_q.fr;
    assign DISPLAY_BLANK = s_q.display_blank_signal;
endmodule : lcdhif_top

// File: sim/lcdhif_props.sv
/* checker for the host port top: pin directions, bus drive and reset state.
   assumes straps are held steady across each reset release. */
`timescale 1ns/10ps
module lcdhif_props (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic PAR_SEL,
    input wire logic BUS_FAMILY_SELECT,
    input wire logic OSC_SOURCE_SELECT,
    input wire logic MASTER_SEL,
    input wire logic CHIP_SELECT_LOW_B,
    input wire logic CHIP_SELECT_HIGH,
    input wire logic RD_STROBE,
    input wire logic WR_STROBE,
    input wire logic [7:0] HOST_DATA_BUS_OE,
    input wire logic ACK_OPEN_DRAIN_OUT_O,
    input wire logic ACK_OPEN_DRAIN_OUT_OE,
    input wire logic XFER_VALID,
    input wire logic OSC_ENABLE,
    input wire logic DISPLAY_CLOCK_PIN_OE,
    input wire logic FRAME_REVERSAL_SIGNAL_OE,
    input wire logic DISPLAY_BLANK_SIGNAL_OE
);
    logic [1:0] up_q; // edges since release, saturating; straps settle by 3
    logic sel; // chip selected
    assign sel = !CHIP_SELECT_LOW_B && CHIP_SELECT_HIGH;
    // count up after reset so direction checks skip the strap latch window
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    reset_clear_a: assert property ($rose(RST_B) |-> !XFER_VALID && HOST_DATA_BUS_OE == 8'h00 && !OSC_ENABLE)
        else $error("outputs not clear after reset");
    osc_run_a: assert property (up_q == 2'h3 |-> OSC_ENABLE == OSC_SOURCE_SELECT)
        else $error("oscillator enable wrong");
    clk_dir_a: assert property (up_q == 2'h3 |-> DISPLAY_CLOCK_PIN_OE == (MASTER_SEL && OSC_SOURCE_SELECT))
        else $error("display clock direction wrong");
    fr_dir_a: assert property (up_q == 2'h3 |-> FRAME_REVERSAL_SIGNAL_OE == MASTER_SEL)
        else $error("frame reversal direction wrong");
    blank_dir_a: assert property (up_q == 2'h3 |-> DISPLAY_BLANK_SIGNAL_OE == MASTER_SEL)
        else $error("blanking direction wrong");
    serial_float_a: assert property (up_q == 2'h3 && !PAR_SEL |-> HOST_DATA_BUS_OE == 8'h00)
        else $error("bus driven in serial-class mode");
    deselect_float_a: assert property ((!sel)[*5] |-> HOST_DATA_BUS_OE == 8'h00)
        else $error("bus driven while deselected");
    rd80_drive_a: assert property ((PAR_SEL && !BUS_FAMILY_SELECT && sel && !RD_STROBE)[*5]
        |-> HOST_DATA_BUS_OE == 8'hFF)
        else $error("80 read not driving");
    rd68_drive_a: assert property ((PAR_SEL && BUS_FAMILY_SELECT && sel && RD_STROBE && WR_STROBE)[*5]
        |-> HOST_DATA_BUS_OE == 8'hFF)
        else $error("68 read not driving");
    wr68_float_a: assert property ((PAR_SEL && BUS_FAMILY_SELECT && !WR_STROBE)[*5] |-> HOST_DATA_BUS_OE == 8'h00)
        else $error("68 write cycle driving bus");
    ack_idle_a: assert property (up_q == 2'h3 && (PAR_SEL || BUS_FAMILY_SELECT)
        |-> !ACK_OPEN_DRAIN_OUT_OE && ACK_OPEN_DRAIN_OUT_O == 1'b0)
        else $error("ack pin misused");
endmodule : lcdhif_props
bind lcdhif_top lcdhif_props u_props (.*);

// File: sim/lcdhif_host_model.sv
/* host processor model: clocked serial, i2c and parallel 80/68 cycles.
   assumes the bench resolves the bus from drv and the design's enables. */
`timescale 1ns/10ps
module lcdhif_host_model (
    output logic link_clk,
    output logic [7:0] drv,
    output logic rd_n,
    output logic wr_n,
    output logic start,
    input wire logic [7:0] bus
);
    // link clock stands low between frames, strobes idle
    initial begin
        {link_clk, drv, rd_n, wr_n, start} = 12'h006;
    end
    // n bits msb first on bit 7, bit 6 mirrors the clock, bits 5..0 tied low
    task automatic shift(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            drv = {b[i], 7'h00};
            #32 link_clk = 1'b1;
            drv[6] = 1'b1;
            #32 link_clk = 1'b0;
            start = 1'b0;
            drv[6] = 1'b0;
        end
        drv[7] = ~drv[7]; // released line shows the inverse, not a stale value
    endtask : shift
    // one i2c byte plus the acknowledge clock; ack is the pulled-up line level
    task automatic i2c_byte(input logic [7:0] b, input logic first, output logic ack);
        start = first;
        shift(b, 8);
        drv[7] = 1'b1;
        #32 link_clk = 1'b1;
        ack = bus[7];
        #32 link_clk = 1'b0;
    endtask : i2c_byte
    // 80: write low then rising edge; 68: enable high then falling edge; link clock rises at the capture
    task automatic par(input logic fam, input logic rw, input logic [7:0] b);
        drv = b;
        {rd_n, wr_n, link_clk} = {1'b1, fam & rw, 1'b0};
        #64 {rd_n, wr_n, link_clk} = {~fam, fam ? rw : 1'b1, 1'b1};
        #64 link_clk = 1'b0;
        drv = ~b;
    endtask : par
    // read: 80 read low, 68 enable high with direction high; host lets go of the bus
    task automatic rd(input logic fam, output logic [7:0] d);
        drv = ~drv;
        {rd_n, wr_n} = {fam, 1'b1};
        #100 d = bus;
        #28 rd_n = ~fam;
    endtask : rd
endmodule : lcdhif_host_model

// File: sim/lcdhif_top_tb_top.sv
/* self-checking bench: each link mode is strapped through a reset, the host model sends
   bytes, expected transfers are queued and a monitor matches them. assumes the bound checker. */
`timescale 1ns/10ps
module lcdhif_top_tb_top;
    logic clk_sys = 1'b0, rst_b = 1'b0, osc_clk = 1'b0; // clocks and reset
    logic par = 1'b0, fam = 1'b0, osc = 1'b0, mst = 1'b0; // straps
    logic cs_l_b = 1'b1, cs_h = 1'b0, dc = 1'b0, blank_req = 1'b0, ack;
    logic [7:0] rdd = 8'h00, got, b, bus, hb_o, hb_oe, drv;
    logic [31:0] rnd = 32'h272B; // lfsr state
    logic link_clk, rd_n, wr_n, start, ack_oe, xv, xp, cl_o, cl_oe, fr_o, fr_oe, bl_o, bl_oe;
    logic [7:0] xd;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    lcdhif_pkg::lcdhif_xfer_t exp_q[$]; // expected transfers, oldest first
    always #5 clk_sys = ~clk_sys;
    always #40 osc_clk = ~osc_clk; // oscillator and external display clock stand-in
    // design drive wins per bit; open-drain ack pulls bit 7 low
    assign bus = ((hb_oe & hb_o) | (~hb_oe & drv)) & ~{ack_oe, 7'h00};
    lcdhif_top dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK_CLK(link_clk), .PAR_SEL(par),
        .BUS_FAMILY_SELECT(fam), .OSC_SOURCE_SELECT(osc), .MASTER_SEL(mst), .CHIP_SELECT_LOW_B(cs_l_b),
        .CHIP_SELECT_HIGH(cs_h), .DATA_COMMAND_SELECT(dc), .RD_STROBE(rd_n), .WR_STROBE(wr_n),
        .HOST_DATA_BUS_I(bus), .I2C_START(start), .READ_DATA(rdd), .OSC_CLK(osc_clk),
        .DISPLAY_CLOCK_PIN_I(cl_oe ? cl_o : osc_clk), .FRAME_REVERSAL_SIGNAL_I(fr_oe & fr_o),
        .DISPLAY_BLANK_SIGNAL_I(bl_oe & bl_o), .BLANK_REQ(blank_req), .HOST_DATA_BUS_O(hb_o),
        .HOST_DATA_BUS_OE(hb_oe), .ACK_OPEN_DRAIN_OUT_O(), .ACK_OPEN_DRAIN_OUT_OE(ack_oe),
        .XFER_VALID(xv), .XFER_DATA(xd), .XFER_IS_PIXEL(xp), .OSC_ENABLE(), .DISP_CLK(),
        .DISPLAY_CLOCK_PIN_O(cl_o), .DISPLAY_CLOCK_PIN_OE(cl_oe), .FRAME_REVERSAL_SIGNAL_O(fr_o),
        .FRAME_REVERSAL_SIGNAL_OE(fr_oe), .DISPLAY_BLANK_SIGNAL_O(bl_o),
        .DISPLAY_BLANK_SIGNAL_OE(bl_oe), .FRAME_REVERSAL(), .DISPLAY_BLANK());
    lcdhif_host_model host (.link_clk(link_clk), .drv(drv), .rd_n(rd_n), .wr_n(wr_n), .start(start), .bus(bus));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // compare seen against expected, count both
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // next random byte, queued as an expected transfer when keep is set
    task automatic pick(input logic keep, input logic pix, output logic [7:0] v);
        rnd = lfsr(rnd);
        v = rnd[7:0];
        if (keep) exp_q.push_back({v, pix});
    endtask : pick
    // monitor: a pulse takes the oldest note; an unexpected pulse always mismatches
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            summarize();
        end
        if (xv === 1'b1) check({xd, xp}, exp_q.size() > 0 ? {exp_q.pop_front()} : ~{xd, xp});
    end
    // one reset per link mode, straps chosen while reset is low
    initial begin
        for (int m = 0; m < 4; m++) begin
            @(negedge clk_sys);
            rst_b = 1'b0;
            {par, fam, mst, osc} = {m == 1 || m == 2, m == 0 || m == 2, m[0], m[1]};
            {cs_l_b, cs_h} = 2'b10;
            blank_req = rnd[16];
            host.shift(8'h00, 1); // link edge inside reset
            repeat (12) @(negedge clk_sys);
            rst_b = 1'b1;
            repeat (6) @(negedge clk_sys);
            case (m)
                0: begin
                    {cs_l_b, cs_h} = 2'b01;
                    host.shift(8'hA5, 5);
                    cs_l_b = 1'b1; // partial byte must be forgotten
                    host.shift(8'h00, 1); // deselected edge clears the count
                    repeat (4) @(negedge clk_sys);
                    cs_l_b = 1'b0;
                    for (int k = 0; k < 3; k++) begin
                        dc = k[0];
                        pick(1'b1, dc, b);
                        host.shift(b, 8);
                    end
                    cs_h = 1'b0;
                    pick(1'b0, 1'b0, b);
                    host.shift(b, 8);
                end
                1, 2: begin
                    {cs_l_b, cs_h} = 2'b01;
                    for (int k = 0; k < 3; k++) begin
                        dc = k[0];
                        pick(1'b1, dc, b);
                        host.par(fam, 1'b0, b);
                    end
                    if (fam) host.par(1'b1, 1'b1, b);
                    rdd = rnd[15:8];
                    host.rd(fam, got);
                    check({got, 1'b0}, {rdd, 1'b0});
                    cs_h = 1'b0;
                    pick(1'b0, 1'b0, b);
                    host.par(fam, 1'b0, b);
                    host.rd(fam, got);
                    check({got, 1'b0}, {b, 1'b0});
                end
                default: begin
                    for (int f = 0; f < 2; f++) begin
                        host.i2c_byte({lcdhif_pkg::I2C_ADDR_HI_DEF[6:2], cs_h, cs_l_b ^ f[0], 1'b0}, 1'b1, ack);
                        check({8'h00, ack}, {8'h00, f[0]});
                        for (int j = 0; j < 5; j++) begin
                            if (j == 0 || j == 2) b = j ? 8'h00 : 8'hC0;
                            else pick(f == 0, j == 1, b);
                            host.i2c_byte(b, 1'b0, ack);
                        end
                    end
                end
            endcase
            repeat (10) @(negedge clk_sys);
            $display("test mode %0d done", m);
        end
        check({8'h00, exp_q.size() == 0}, 9'h001);
        summarize();
    end
endmodule : lcdhif_top_tb_top
